/* File: bench/spi_master_slave_port_bench.sv */
`timescale 1ns/100ps
module spi_master_slave_port_bench;
  localparam logic [3:0] C  = spi_port_pkg::CTRL_OFS;
  localparam logic [3:0] S  = spi_port_pkg::STAT_OFS;
  localparam logic [3:0] D  = spi_port_pkg::DATA_OFS;
  localparam logic [1:0] OK = spi_port_pkg::RESP_OKAY;
  logic        clock, resetn, awvalid, wvalid, bready, arvalid, rready;
  logic        awready, wready, bvalid, arready, rvalid, irq;
  logic [3:0]  awaddr, araddr;
  logic [31:0] wdata, rdata, seed, sd;
  logic [1:0]  bresp, rresp;
  logic        global_irq_en, vector_taken, ss_is_output, ss_lo, last_sck;
  logic        sck_out, sck_oe_n, mosi_out, mosi_oe_n, miso_out, miso_oe_n;
  logic        peer_sck, peer_mosi, peer_miso, peer_ss_n;
  logic [34:0] e;
  logic [7:0]  tx, px;
  logic [2:0]  m;
  logic [3:0]  wstrb;
  logic        miso_dir;
  logic [34:0] exp_q[$];
  int          num_errors = 0, comparisons = 0, cyc = 0, cnt = 0, half_seen = 0, hv;
  wire         sck_w  = sck_oe_n ? peer_sck : sck_out;
  wire         mosi_w = mosi_oe_n ? peer_mosi : mosi_out;
  wire         miso_w = miso_oe_n ? peer_miso : miso_out;
  wire         ss_w   = peer_ss_n & ~ss_lo;

  spi_port u_spi_port (.clock, .resetn, .awaddr, .awvalid, .awready, .wdata, .wstrb,
    .wvalid, .wready, .bresp, .bvalid, .bready, .araddr, .arvalid, .arready, .rdata, .rresp,
    .rvalid, .rready, .global_irq_en, .vector_taken, .irq, .sck_in(sck_w), .sck_out,
    .sck_oe_n, .sck_is_output(1'b1), .mosi_in(mosi_w), .mosi_out, .mosi_oe_n,
    .mosi_is_output(1'b1), .miso_in(miso_w), .miso_out, .miso_oe_n, .miso_is_output(miso_dir),
    .ss_n_in(ss_w), .ss_is_output);

  spi_peer u_spi_peer (.clock, .sck(sck_w), .ss_n(ss_w), .mosi(mosi_w), .miso(miso_w),
    .peer_sck, .peer_mosi, .peer_miso, .peer_ss_n);

  initial begin
    clock = 1'b0;
    forever #5 clock = ~clock;
  end

  task automatic stop_test();
    $display("Errors %0d, comparisons %0d", num_errors, comparisons);
    if (num_errors == 0 && comparisons > 0) begin
      $display("Testbench passed");
    end else begin
      $display("Testbench failed");
    end
    $finish;
  endtask : stop_test

  task automatic chk(input logic [34:0] s, input logic [34:0] x);
    comparisons++;
    if (s !== x) begin
      num_errors++;
      $display("[ERR] %0t seen %h expected %h", $time, s, x);
    end
  endtask : chk

  function automatic logic [7:0] rnd();
    seed = seed ^ (seed << 13);
    seed = seed ^ (seed >> 17);
    seed = seed ^ (seed << 5);
    return seed[7:0];
  endfunction : rnd

  // Handshakes are judged at the falling edge, where ready and valid are settled
  task automatic acc(input logic wr, input logic [3:0] a, input logic [7:0] d,
                     input logic [1:0] r, input logic c);
    logic ha, hw, hb;
    exp_q.push_back({c, r, wr ? 32'h0 : {24'h0, d}});
    @(posedge clock);
    if (wr) begin
      awaddr <= a;
      wdata <= {24'h0, d};
      awvalid <= 1'b1;
      wvalid <= 1'b1;
      bready <= 1'b1;
    end else begin
      araddr <= a;
      arvalid <= 1'b1;
      rready <= 1'b1;
    end
    hb = 1'b0;
    while (!hb) begin
      @(negedge clock);
      ha = (awvalid && awready) || (arvalid && arready);
      hw = wvalid && wready;
      hb = (bvalid && bready) || (rvalid && rready);
      @(posedge clock);
      if (ha) begin
        awvalid <= 1'b0;
        arvalid <= 1'b0;
      end
      if (hw) wvalid <= 1'b0;
      if (hb) begin
        bready <= 1'b0;
        rready <= 1'b0;
      end
    end
  endtask : acc

  task automatic wait_irq();
    int n;
    n = 0;
    while (irq !== 1'b1 && n < 3000) begin
      @(negedge clock);
      n++;
    end
    chk(35'(irq), 35'h1);
  endtask : wait_irq

  always @(negedge clock) begin
    if ((bvalid && bready) || (rvalid && rready)) begin
      e = exp_q.pop_front();
      sd = (bvalid || !e[34]) ? 32'h0 : rdata;
      chk({1'b0, bvalid ? bresp : rresp, sd}, {1'b0, e[33:32], e[34] ? e[31:0] : 32'h0});
    end
  end

  always @(posedge clock) begin
    cyc <= cyc + 1;
    cnt <= (sck_out != last_sck) ? 1 : cnt + 1;
    if (sck_out != last_sck) half_seen <= cnt;
    last_sck <= sck_out;
    if (cyc == 60000) begin
      num_errors++;
      stop_test();
    end
  end

  initial begin
    {resetn, awvalid, wvalid, bready, arvalid, rready, vector_taken, ss_lo} = '0;
    {awaddr, araddr, wdata, last_sck} = '0;
    wstrb = 4'hF;
    miso_dir = 1'b1;
    {global_irq_en, ss_is_output} = 2'h3;
    seed = 32'h4583;
    repeat (20) @(posedge clock);
    resetn <= 1'b1;
    acc(0, C, 8'h00, OK, 1);
    acc(0, S, 8'h00, OK, 1);
    acc(0, 4'hC, 8'h00, spi_port_pkg::RESP_SLVERR, 1);
    wstrb <= 4'h0;
    acc(1, C, 8'hFF, OK, 1);
    wstrb <= 4'hF;
    acc(0, C, 8'h00, OK, 1);
    acc(1, S, 8'hFF, OK, 1);
    acc(0, S, 8'h01, OK, 1);
    for (int k = 0; k < 8; k++) begin
      m = {k[0] ^ k[2], k[1:0]};
      hv = ((k[2] ? 1 : 2) << (2 * k[1:0])) >> (k[1:0] == 2'h3);
      tx = rnd();
      px = rnd();
      ss_lo <= 1'b0;
      acc(1, S, {7'h0, k[2]}, OK, 1);
      acc(1, C, {3'b111, 1'b1, m[1:0], k[1:0]} ^ {2'b0, ~m[2], 5'h0}, OK, 1);
      ss_lo <= 1'b1;
      // Let the released-line wander stop before the first bit is loaded
      @(posedge clock);
      u_spi_peer.load(px, m);
      acc(1, D, tx, OK, 1);
      wait_irq();
      chk(35'(u_spi_peer.rx), 35'(tx));
      chk(35'(half_seen), 35'(hv));
      chk(35'(sck_out), 35'(m[1]));
      acc(0, S, {7'h40, k[2]}, OK, 1);
      acc(0, D, px, OK, hv > 2);
      chk(35'(irq), 35'h0);
    end
    ss_lo <= 1'b0;
    acc(1, S, 8'h00, OK, 1);
    acc(1, C, 8'hD3, OK, 1);
    ss_lo <= 1'b1;
    @(posedge clock);
    u_spi_peer.load(px, 3'h0);
    acc(1, D, tx, OK, 1);
    acc(1, D, ~tx, OK, 1);
    wait_irq();
    chk(35'(u_spi_peer.rx), 35'(tx));
    acc(0, S, 8'hC0, OK, 1);
    global_irq_en <= 1'b0;
    @(negedge clock);
    chk(35'(irq), 35'h0);
    @(posedge clock);
    global_irq_en <= 1'b1;
    acc(0, D, px, OK, 1);
    acc(0, S, 8'h00, OK, 1);
    ss_lo <= 1'b0;
    acc(1, C, 8'h13, OK, 1);
    acc(1, D, tx, OK, 1);
    repeat (300) @(negedge clock);
    acc(0, S, 8'h00, OK, 1);
    for (int j = 0; j < 4; j++) begin
      m = {j[0], j[1:0]};
      tx = rnd();
      px = rnd();
      acc(1, C, {2'b11, m[2], 1'b0, m[1:0], 2'b00}, OK, 1);
      acc(1, D, tx, OK, 1);
      u_spi_peer.load(px, m);
      if (j == 2) begin
        u_spi_peer.xfer(3);
        // Select must stay high long enough to pass the synchroniser
        repeat (4) @(posedge clock);
        u_spi_peer.load(px, m);
      end
      u_spi_peer.xfer(8);
      wait_irq();
      @(posedge clock);
      vector_taken <= 1'b1;
      @(posedge clock);
      vector_taken <= 1'b0;
      @(negedge clock);
      chk(35'(irq), 35'h0);
      acc(0, D, px, OK, 1);
      chk(35'(u_spi_peer.rx), 35'(tx));
    end
    ss_is_output <= 1'b0;
    u_spi_peer.load(8'h00, 3'h0);
    acc(1, C, 8'hD0, OK, 1);
    ss_lo <= 1'b1;
    wait_irq();
    acc(0, C, 8'hC0, OK, 1);
    acc(0, S, 8'h80, OK, 1);
    chk(35'({sck_oe_n, mosi_oe_n}), 35'h3);
    chk(35'(miso_oe_n), 35'h0);
    miso_dir <= 1'b0;
    @(negedge clock);
    chk(35'(miso_oe_n), 35'h1);
    @(posedge clock);
    ss_lo <= 1'b0;
    acc(0, D, 8'h00, OK, 0);
    acc(0, S, 8'h00, OK, 1);
    stop_test();
  end
endmodule : spi_master_slave_port_bench

/* File: bench/spi_peer.sv */
`timescale 1ns/100ps
module spi_peer (
  input  wire logic clock,
  input  wire logic sck,
  input  wire logic ss_n,
  input  wire logic mosi,
  input  wire logic miso,
  output      logic peer_sck,
  output      logic peer_mosi,
  output      logic peer_miso,
  output      logic peer_ss_n
);
  logic [7:0] sr;
  logic [7:0] rx;
  logic       lsb;
  logic       clock_polarity;
  logic       clock_phase;
  logic       mst;
  logic       first;
  wire        din = mst ? miso : mosi;

  initial begin
    {sr, rx, lsb, clock_polarity, clock_phase, mst, first} = '0;
    {peer_sck, peer_mosi, peer_miso, peer_ss_n} = 4'h1;
  end

  task automatic put();
    if (mst) peer_mosi = lsb ? sr[0] : sr[7];
    else peer_miso = lsb ? sr[0] : sr[7];
  endtask : put

  task automatic load(input logic [7:0] b, input logic [2:0] m);
    sr = b;
    {lsb, clock_polarity, clock_phase} = m;
    first = 1'b1;
    peer_sck = m[1];
    put();
  endtask : load

  always @(sck) begin
    if (!ss_n) begin
      if ((sck != clock_polarity) != clock_phase) begin
        rx = lsb ? {din, rx[7:1]} : {rx[6:0], din};
      end else begin
        if (!first || !clock_phase) sr = lsb ? sr >> 1 : sr << 1;
        first = 1'b0;
        put();
      end
    end
  end

  // Released lines wander so a stale level never passes for data
  always @(posedge clock) begin
    if (ss_n) begin
      peer_miso <= ~peer_miso;
      if (!mst) peer_mosi <= ~peer_mosi;
    end
  end

  // 80 ns link clock keeps each level well above two system clocks
  task automatic xfer(input int n);
    #3;
    mst = 1'b1;
    put();
    peer_ss_n = 1'b0;
    #40;
    repeat (n) begin
      peer_sck = ~clock_polarity;
      #40;
      peer_sck = clock_polarity;
      #40;
    end
    #40;
    peer_ss_n = 1'b1;
    mst = 1'b0;
  endtask : xfer
endmodule : spi_peer

/* File: hdl/spi_pin_sync.sv */
`timescale 1ns/100ps
module spi_pin_sync #(
  parameter int               WIDTH = 1,
  parameter logic [WIDTH-1:0] INIT  = '0
) (
  input  wire logic             clock,
  input  wire logic             resetn,
  input  wire logic [WIDTH-1:0] pins,
  output      logic [WIDTH-1:0] synced
);
  typedef struct packed {
    logic [WIDTH-1:0] meta;
    logic [WIDTH-1:0] stable;
  } sync_state_t;

  sync_state_t state_reg;
  sync_state_t state_next;

  // The first stage feeds only the second stage
  always_comb begin
    state_next        = state_reg;
    state_next.meta   = pins;
    state_next.stable = state_reg.meta;
  end

  always_ff @(posedge clock or negedge resetn) begin
    if (!resetn) begin
      state_reg <= {INIT, INIT};
    end else begin
      state_reg <= state_next;
    end
  end

  assign synced = state_reg.stable;
endmodule : spi_pin_sync

/* File: hdl/spi_port.sv */
// Implementation choices: register access over AXI4-Lite and the placing of the registers.
`timescale 1ns/100ps
module spi_port (
  input  wire logic        clock,
  input  wire logic        resetn,
  input  wire logic [3:0]  awaddr,
  input  wire logic        awvalid,
  output      logic        awready,
  input  wire logic [31:0] wdata,
  input  wire logic [3:0]  wstrb,
  input  wire logic        wvalid,
  output      logic        wready,
  output      logic [1:0]  bresp,
  output      logic        bvalid,
  input  wire logic        bready,
  input  wire logic [3:0]  araddr,
  input  wire logic        arvalid,
  output      logic        arready,
  output      logic [31:0] rdata,
  output      logic [1:0]  rresp,
  output      logic        rvalid,
  input  wire logic        rready,
  input  wire logic        global_irq_en,
  input  wire logic        vector_taken,
  output      logic        irq,
  input  wire logic        sck_in,
  output      logic        sck_out,
  output      logic        sck_oe_n,
  input  wire logic        sck_is_output,
  input  wire logic        mosi_in,
  output      logic        mosi_out,
  output      logic        mosi_oe_n,
  input  wire logic        mosi_is_output,
  input  wire logic        miso_in,
  output      logic        miso_out,
  output      logic        miso_oe_n,
  input  wire logic        miso_is_output,
  input  wire logic        ss_n_in,
  input  wire logic        ss_is_output
);
  typedef struct packed {
    logic [7:0]                ctrl;
    logic                      dbl;
    logic                      done;
    logic                      write_collision_flag;
    logic                      armed;
    logic [7:0]                rx_buf;
    logic [7:0]                shreg;
    logic [7:0]                tx_hold;
    logic                      samp;
    logic                      have;
    logic [3:0]                bitcnt;
    logic [6:0]                div_cnt;
    logic                      sck;
    logic                      sck_p;
    spi_port_pkg::xfer_state_t st;
    logic                      aw_got;
    logic                      w_got;
    logic [3:0]                waddr;
    logic [7:0]                wdat;
    logic                      wstb;
    logic                      bvalid;
    logic [1:0]                bresp;
    logic                      rvalid;
    logic [1:0]                rresp;
    logic [7:0]                rdata;
  } port_state_t;

  port_state_t            s_reg;
  port_state_t            s_next;
  logic [3:0]             pins_s;
  logic                   sck_s;
  logic                   mosi_s;
  logic                   miso_s;
  logic                   ss_s;
  logic                   en;
  logic                   master;
  logic                   clock_polarity;
  logic                   clock_phase;
  logic                   lsb;
  logic                   busy;
  logic                   wr_fire;
  logic                   rd_fire;
  logic                   data_acc;
  logic                   fault;
  logic                   edge_go;
  logic                   new_lvl;
  logic                   din;
  logic [6:0]             half;
  spi_port_pkg::reg_sel_t wsel;
  spi_port_pkg::reg_sel_t rsel;

  function automatic spi_port_pkg::reg_sel_t reg_sel(input logic [3:0] a);
    unique case (a)
      spi_port_pkg::CTRL_OFS: reg_sel = spi_port_pkg::SEL_CTRL;
      spi_port_pkg::STAT_OFS: reg_sel = spi_port_pkg::SEL_STAT;
      spi_port_pkg::DATA_OFS: reg_sel = spi_port_pkg::SEL_DATA;
      default:                reg_sel = spi_port_pkg::SEL_NONE;
    endcase
  endfunction : reg_sel

  function automatic logic [7:0] shift_in(input logic [7:0] v, input logic b, input logic lf);
    shift_in = lf ? {b, v[7:1]} : {v[6:0], b};
  endfunction : shift_in

  spi_pin_sync #(
    .WIDTH (4),
    .INIT  (4'h1)
  ) u_sync (
    .clock  (clock),
    .resetn (resetn),
    .pins   ({sck_in, mosi_in, miso_in, ss_n_in}),
    .synced (pins_s)
  );

  assign sck_s  = pins_s[3];
  assign mosi_s = pins_s[2];
  assign miso_s = pins_s[1];
  assign ss_s   = pins_s[0];

  assign en     = s_reg.ctrl[spi_port_pkg::PORT_EN_POS];
  assign master = s_reg.ctrl[spi_port_pkg::MASTER_POS];
  assign clock_polarity   = s_reg.ctrl[spi_port_pkg::CLOCK_POLARITY_POS];
  assign clock_phase   = s_reg.ctrl[spi_port_pkg::CLOCK_PHASE_POS];
  assign lsb    = s_reg.ctrl[spi_port_pkg::ORDER_POS];
  assign half   = s_reg.dbl ? spi_port_pkg::HALF_DBL[s_reg.ctrl[1:0]]
                            : spi_port_pkg::HALF_NORM[s_reg.ctrl[1:0]];
  // A slave is busy between its first and eighth sample
  assign busy    = (s_reg.st == spi_port_pkg::ST_SHIFT) || (s_reg.bitcnt != 4'h0);
  assign wr_fire = s_reg.aw_got && s_reg.w_got && !s_reg.bvalid;
  assign rd_fire = arvalid && arready;
  assign wsel    = reg_sel(s_reg.waddr);
  assign rsel    = reg_sel(araddr);
  assign din     = master ? miso_s : mosi_s;
  assign fault   = en && master && !ss_is_output && !ss_s;

  always_comb begin
    s_next   = s_reg;
    edge_go  = 1'b0;
    new_lvl  = s_reg.sck;
    data_acc = (wr_fire && wsel == spi_port_pkg::SEL_DATA)
            || (rd_fire && rsel == spi_port_pkg::SEL_DATA);

    // Write channels are taken in either order
    if (awvalid && awready) begin
      s_next.aw_got = 1'b1;
      s_next.waddr  = awaddr;
    end
    if (wvalid && wready) begin
      s_next.w_got = 1'b1;
      s_next.wdat  = wdata[7:0];
      s_next.wstb  = wstrb[0];
    end
    if (s_reg.bvalid && bready) begin
      s_next.bvalid = 1'b0;
    end
    if (s_reg.rvalid && rready) begin
      s_next.rvalid = 1'b0;
    end

    if (rd_fire) begin
      s_next.rvalid = 1'b1;
      s_next.rresp  = spi_port_pkg::RESP_OKAY;
      unique case (rsel)
        spi_port_pkg::SEL_CTRL: s_next.rdata = s_reg.ctrl;
        spi_port_pkg::SEL_STAT: s_next.rdata = {s_reg.done, s_reg.write_collision_flag, 5'h00, s_reg.dbl};
        spi_port_pkg::SEL_DATA: s_next.rdata = s_reg.rx_buf;
        spi_port_pkg::SEL_NONE: begin
          s_next.rdata = 8'h00;
          s_next.rresp = spi_port_pkg::RESP_SLVERR;
        end
      endcase
    end

    // Flag clears come first so that any set below in the same cycle wins
    if (data_acc && s_reg.armed) begin
      s_next.done  = 1'b0;
      s_next.write_collision_flag  = 1'b0;
      s_next.armed = 1'b0;
    end
    if (rd_fire && rsel == spi_port_pkg::SEL_STAT && (s_reg.done || s_reg.write_collision_flag)) begin
      s_next.armed = 1'b1;
    end
    if (vector_taken) begin
      s_next.done = 1'b0;
    end

    // Last bit of a trailing-phase master byte joins the shifter once SCK is idle
    if (s_reg.st == spi_port_pkg::ST_IDLE && s_reg.have && s_reg.bitcnt == 4'h0) begin
      s_next.shreg = shift_in(s_reg.shreg, s_reg.samp, lsb);
      s_next.have  = 1'b0;
    end

    if (wr_fire) begin
      s_next.aw_got = 1'b0;
      s_next.w_got  = 1'b0;
      s_next.bvalid = 1'b1;
      s_next.bresp  = (wsel == spi_port_pkg::SEL_NONE) ? spi_port_pkg::RESP_SLVERR
                                                      : spi_port_pkg::RESP_OKAY;
      if (s_reg.wstb) begin
        unique case (wsel)
          spi_port_pkg::SEL_CTRL: s_next.ctrl = s_reg.wdat;
          spi_port_pkg::SEL_STAT: s_next.dbl  = s_reg.wdat[spi_port_pkg::DBL_POS];
          spi_port_pkg::SEL_DATA: begin
            if (busy) begin
              s_next.write_collision_flag = 1'b1;
            end else begin
              s_next.shreg   = s_reg.wdat;
              s_next.tx_hold = s_reg.wdat;
              if (en && master) begin
                s_next.st      = spi_port_pkg::ST_SHIFT;
                s_next.div_cnt = 7'h00;
                s_next.bitcnt  = 4'h0;
                s_next.have    = 1'b0;
              end
            end
          end
          spi_port_pkg::SEL_NONE: ;
        endcase
      end
    end

    // Disabling the port or leaving master role abandons a byte in flight
    if (!s_next.ctrl[spi_port_pkg::PORT_EN_POS]
        || (s_reg.st == spi_port_pkg::ST_SHIFT && !s_next.ctrl[spi_port_pkg::MASTER_POS])) begin
      s_next.st     = spi_port_pkg::ST_IDLE;
      s_next.bitcnt = 4'h0;
      s_next.have   = 1'b0;
    end
    if (en && !master && ss_s) begin
      if (s_reg.bitcnt != 4'h0) begin
        s_next.shreg = s_reg.tx_hold;
      end
      s_next.bitcnt = 4'h0;
      s_next.have   = 1'b0;
    end

    // Edge sources: own divider as master, synchronised pin as slave
    s_next.sck_p = sck_s;
    if (s_reg.st == spi_port_pkg::ST_SHIFT && s_next.st == spi_port_pkg::ST_SHIFT) begin
      if (s_reg.div_cnt == half - 7'h01) begin
        s_next.div_cnt = 7'h00;
        edge_go        = 1'b1;
        new_lvl        = !s_reg.sck;
      end else begin
        s_next.div_cnt = s_reg.div_cnt + 7'h01;
      end
    end else if (en && !master && !ss_s) begin
      edge_go = (sck_s != s_reg.sck_p);
      new_lvl = sck_s;
    end
    if (s_next.st == spi_port_pkg::ST_IDLE) begin
      s_next.sck     = clock_polarity;
      s_next.div_cnt = 7'h00;
    end

    if (edge_go) begin
      if (master) begin
        s_next.sck = new_lvl;
      end
      // Leading edge leaves the idle level; phase picks sample or setup
      if ((new_lvl != clock_polarity) ^ clock_phase) begin
        // A master must not move MOSI on a sample edge, so its last bit waits in samp
        if (s_next.bitcnt == 4'h7 && !master) begin
          s_next.shreg  = shift_in(s_next.shreg, din, lsb);
          s_next.bitcnt = spi_port_pkg::BITS_PER_BYTE;
          s_next.have   = 1'b0;
        end else begin
          s_next.samp   = din;
          s_next.have   = 1'b1;
          s_next.bitcnt = s_next.bitcnt + 4'h1;
        end
      end else if (s_next.have) begin
        s_next.shreg = shift_in(s_next.shreg, s_next.samp, lsb);
        s_next.have  = 1'b0;
      end
      // A master holds the byte until SCK is back at its idle level
      if (s_next.bitcnt == spi_port_pkg::BITS_PER_BYTE && (!master || new_lvl == clock_polarity)) begin
        s_next.rx_buf = s_next.have ? shift_in(s_next.shreg, s_next.samp, lsb)
                                    : s_next.shreg;
        s_next.done   = 1'b1;
        s_next.bitcnt = 4'h0;
        s_next.st     = spi_port_pkg::ST_IDLE;
      end
    end

    if (fault) begin
      s_next.ctrl[spi_port_pkg::MASTER_POS] = 1'b0;
      s_next.done   = 1'b1;
      s_next.st     = spi_port_pkg::ST_IDLE;
      s_next.bitcnt = 4'h0;
      s_next.have   = 1'b0;
      s_next.sck    = clock_polarity;
    end
  end

  always_ff @(posedge clock or negedge resetn) begin
    if (!resetn) begin
      s_reg        <= '0;
      s_reg.ctrl   <= spi_port_pkg::CTRL_RESET;
      s_reg.shreg  <= spi_port_pkg::DATA_RESET;
      s_reg.sck_p  <= 1'b0;
      s_reg.st     <= spi_port_pkg::ST_IDLE;
    end else begin
      s_reg <= s_next;
    end
  end

  assign awready = !s_reg.aw_got && !s_reg.bvalid;
  assign wready  = !s_reg.w_got && !s_reg.bvalid;
  assign bvalid  = s_reg.bvalid;
  assign bresp   = s_reg.bresp;
  assign arready = !s_reg.rvalid;
  assign rvalid  = s_reg.rvalid;
  assign rresp   = s_reg.rresp;
  assign rdata   = {24'h000000, s_reg.rdata};

  assign irq = s_reg.ctrl[spi_port_pkg::IRQ_EN_POS] && s_reg.done && global_irq_en;

  // Pin drivers; enables are low while driving
  assign sck_out   = s_reg.sck;
  assign sck_oe_n  = !(en && master && sck_is_output);
  assign mosi_out  = lsb ? s_reg.shreg[0] : s_reg.shreg[7];
  assign mosi_oe_n = !(en && master && mosi_is_output);
  assign miso_out  = lsb ? s_reg.shreg[0] : s_reg.shreg[7];
  assign miso_oe_n = !(en && !master && !ss_s && miso_is_output);

  default clocking cb @(posedge clock);
  endclocking
  default disable iff (!resetn);

  property p_reserved;
    rd_fire && rsel == spi_port_pkg::SEL_STAT |=> s_reg.rvalid && s_reg.rdata[5:1] == 5'h00;
  endproperty
  a_reserved: assert property (p_reserved)
    else $error("reserved status bits read nonzero");

  property p_irq;
    $rose(s_reg.done) && s_reg.ctrl[spi_port_pkg::IRQ_EN_POS] && global_irq_en |-> irq;
  endproperty
  a_irq: assert property (p_irq)
    else $error("interrupt missing after done flag");

  property p_disabled;
    !en |=> !busy;
  endproperty
  a_disabled: assert property (p_disabled)
    else $error("transfer active while port disabled");

  property p_fault;
    fault |=> !master && s_reg.done && s_reg.st == spi_port_pkg::ST_IDLE && sck_oe_n;
  endproperty
  a_fault: assert property (p_fault)
    else $error("select low in master role not handled");

  property p_slave_reset;
    en && !master && ss_s |=> s_reg.bitcnt == 4'h0 && !s_reg.have;
  endproperty
  a_slave_reset: assert property (p_slave_reset)
    else $error("slave kept partial byte with select high");

  property p_write_collision_flag;
    wr_fire && s_reg.wstb && wsel == spi_port_pkg::SEL_DATA && busy && !edge_go && !fault
      |=> s_reg.write_collision_flag && $stable(s_reg.shreg) && $stable(s_reg.bitcnt);
  endproperty
  a_write_collision_flag: assert property (p_write_collision_flag)
    else $error("colliding write disturbed transfer or missed flag");

  property p_fast;
    (s_reg.st == spi_port_pkg::ST_SHIFT && master && s_reg.dbl && s_reg.ctrl[1:0] == 2'h0)
      ##1 (s_reg.st == spi_port_pkg::ST_SHIFT && $stable(s_reg.ctrl))
      |-> s_reg.sck != $past(s_reg.sck);
  endproperty
  a_fast: assert property (p_fast)
    else $error("doubled fastest rate did not toggle SCK every cycle");

  property p_done;
    $fell(s_reg.st == spi_port_pkg::ST_SHIFT) && master && en && $stable(s_reg.ctrl)
      |-> s_reg.done && s_reg.sck == clock_polarity && s_reg.bitcnt == 4'h0;
  endproperty
  a_done: assert property (p_done)
    else $error("master byte ended without flag or idle SCK");

  property p_clear;
    s_reg.armed && data_acc && !edge_go && !fault && !busy && !vector_taken
      |=> !s_reg.done && !s_reg.write_collision_flag;
  endproperty
  a_clear: assert property (p_clear)
    else $error("status then data access did not clear flags");
endmodule : spi_port

/* File: hdl/spi_port_pkg.sv */
package spi_port_pkg;
  // Register byte offsets on the 32-bit bus
  localparam logic [3:0] CTRL_OFS = 4'h0;
  localparam logic [3:0] STAT_OFS = 4'h4;
  localparam logic [3:0] DATA_OFS = 4'h8;

  localparam logic [7:0] CTRL_RESET = 8'h00;
  localparam logic [7:0] DATA_RESET = 8'h00;

  // Control field positions
  localparam int IRQ_EN_POS  = 7;
  localparam int PORT_EN_POS = 6;
  localparam int ORDER_POS   = 5;
  localparam int MASTER_POS  = 4;
  localparam int CLOCK_POLARITY_POS    = 3;
  localparam int CLOCK_PHASE_POS    = 2;
  localparam int RATE_LO_POS = 0;

  // Status field positions
  localparam int DONE_POS = 7;
  localparam int WRITE_COLLISION_FLAG_POS = 6;
  localparam int DBL_POS  = 0;

  // Half periods of SCK in system clocks, indexed by the two rate bits
  localparam logic [3:0][6:0] HALF_NORM = {7'h40, 7'h20, 7'h08, 7'h02};
  localparam logic [3:0][6:0] HALF_DBL  = {7'h20, 7'h10, 7'h04, 7'h01};

  localparam logic [3:0] BITS_PER_BYTE = 4'h8;

  localparam logic [1:0] RESP_OKAY   = 2'h0;
  localparam logic [1:0] RESP_SLVERR = 2'h2;

  typedef enum logic [1:0] {
    ST_IDLE  = 2'h0,
    ST_SHIFT = 2'h1
  } xfer_state_t;

  typedef enum logic [1:0] {
    SEL_CTRL = 2'h0,
    SEL_STAT = 2'h1,
    SEL_DATA = 2'h2,
    SEL_NONE = 2'h3
  } reg_sel_t;
endpackage : spi_port_pkg
